// File: common/adc_frame_pkg.sv
// constants and types shared by the converter frame and alarm control logic
package adc_frame_pkg;

   localparam int CODE_W  = 12;
   localparam int WORD_W  = 16;
   localparam int PAD_W   = WORD_W - CODE_W;
   localparam int NUM_CH  = 8;
   localparam int CH_W    = 3;
   localparam int HYST_W  = 8;
   localparam int ALARM_W = 2 * NUM_CH;
   localparam int CMP_W   = CODE_W + 2;

   // serial frame
   localparam int              CFG_EDGES = 16;
   localparam logic [4:0]      EDGE_LAST = 5'h0F;
   localparam logic [4:0]      EDGE_DONE = 5'h10;
   localparam logic [PAD_W-1:0] PAD_ZERO = 4'h0;

   // configuration word fields
   localparam int         OP_POS    = 12;
   localparam int         OP_W      = 4;
   localparam int         CH_POS    = 8;
   localparam int         RANGE_POS = 0;
   localparam int         RANGE_W   = 4;
   localparam logic [3:0] OP_NOP      = 4'h0;
   localparam logic [3:0] OP_PROG     = 4'h1;
   localparam logic [3:0] OP_READ_ALM = 4'h8;
   localparam logic [3:0] OP_AUTO     = 4'hA;
   localparam logic [3:0] OP_MAN      = 4'hC;

   // nine input ranges: codes 0..4 bipolar, 5..8 unipolar
   localparam logic [3:0] RANGE_COUNT   = 4'h9;
   localparam logic [3:0] RANGE_DEFAULT = 4'h0;

   // alarm comparison offsets
   localparam logic [CMP_W-1:0] HI_CLR_OFS = 14'h0002;
   localparam logic [CMP_W-1:0] LO_OFS     = 14'h0001;

   // reset / power-down pin timing at the reference clock
   localparam int REF_CLK_PS  = 4000;
   localparam int RST_MIN_NS  = 40;
   localparam int RST_MAX_NS  = 100;
   localparam int PD_MIN_NS   = 400;
   localparam int RST_MIN_CYC = (RST_MIN_NS * 1000 + REF_CLK_PS - 1) / REF_CLK_PS;
   localparam int RST_MAX_CYC = (RST_MAX_NS * 1000) / REF_CLK_PS;
   localparam int PD_MIN_CYC  = (PD_MIN_NS * 1000 + REF_CLK_PS - 1) / REF_CLK_PS;
   localparam int LOW_CNT_W   = 7;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_CONV  = 3'b010,
      ST_READY = 3'b100
   } conv_state_t;

endpackage

// File: rtl/adc_frame_alarm_control.sv
// serial frame, conversion sequencing and threshold alarms of a 12-bit multichannel converter

// Summary of operation
// - results are unsigned straight binary, same for every range and channel
// - result is a 12-bit code, one step is span divided by 4096
// - nine input ranges per channel, five bipolar and four unipolar
// - alarm pin active high, updates only on 16th falling serial edge
// - each channel has its own high and low threshold and hysteresis
// - high alarm sets when code exceeds threshold plus hysteresis
// - high alarm clears when code at or below threshold minus hysteresis minus 2
// - low alarm sets when code below threshold minus hysteresis minus 1
// - active flag follows the present alarm condition
// - tripped flag sets with alarm and holds until flags are read
// - chip-select fall starts a frame and a conversion of selected channel
// - channel converted was selected during the previous frame
// - serial input captured and output launched on falling serial edges
// - one input bit captured on each of the first 16 falling edges
// - configuration from a frame applies at the next chip-select fall
// - output leaves high impedance at select low, low for 15 edges
// - MSB on 16th edge, one bit per edge, then chain input bits, released at select high
// - reset pin low 40 to 100 ns resets program registers only
// - reset pin low 400 ns or more powers down and resets registers
// - while powered down all other digital inputs are ignored
// - result word is 12 code bits MSB first followed by four zeros
// - after the 16th edge each edge shifts the chain input in
module adc_frame_alarm_control (
   input  wire logic                                                  I_REF_CLK,
   input  wire logic                                                  I_SYS_RST,
   input  wire logic                                                  I_SCLK,
   input  wire logic                                                  I_CS_N,
   input  wire logic                                                  I_SDI,
   input  wire logic                                                  I_DAISY,
   input  wire logic                                                  I_RESET_POWERDOWN_PIN_N,
   input  wire logic                                                  I_CONV_DONE,
   input  wire logic [adc_frame_pkg::CODE_W-1:0]                      I_CONV_CODE,
   input  wire logic [adc_frame_pkg::NUM_CH-1:0][adc_frame_pkg::CODE_W-1:0] I_HI_THRESH,
   input  wire logic [adc_frame_pkg::NUM_CH-1:0][adc_frame_pkg::HYST_W-1:0] I_HI_HYST,
   input  wire logic [adc_frame_pkg::NUM_CH-1:0][adc_frame_pkg::CODE_W-1:0] I_LO_THRESH,
   input  wire logic [adc_frame_pkg::NUM_CH-1:0][adc_frame_pkg::HYST_W-1:0] I_LO_HYST,
   output logic                                                       O_SDO,
   output logic                                                       O_SDO_OE,
   output logic                                                       O_ALARM,
   output logic                                                       O_CONV_START,
   output logic [adc_frame_pkg::CH_W-1:0]                             O_CONV_CHANNEL,
   output logic                                                       O_RESULT_READY,
   output logic [adc_frame_pkg::NUM_CH-1:0][adc_frame_pkg::RANGE_W-1:0] O_RANGE,
   output logic [adc_frame_pkg::ALARM_W-1:0]                          O_ALARM_ACTIVE,
   output logic [adc_frame_pkg::ALARM_W-1:0]                          O_ALARM_TRIPPED,
   output logic                                                       O_POWER_DOWN_STATE
);

   typedef struct packed {
      logic                                                         cs_s1;
      logic                                                         cs_s2;
      logic                                                         cs_s3;
      logic                                                         pin_s1;
      logic                                                         pin_s2;
      logic                                                         tg_s1;
      logic                                                         tg_s2;
      logic                                                         tg_s3;
      logic [adc_frame_pkg::LOW_CNT_W-1:0]                          low_cnt;
      logic                                                         power_down_state;
      adc_frame_pkg::conv_state_t                                   state;
      logic [adc_frame_pkg::WORD_W-1:0]                             pend_word;
      logic                                                         pend_vld;
      logic                                                         prog_done;
      logic                                                         armed;
      logic                                                         auto_scan;
      logic [adc_frame_pkg::CH_W-1:0]                               sel;
      logic                                                         conv_start;
      logic [adc_frame_pkg::CH_W-1:0]                               conv_chan;
      logic [adc_frame_pkg::WORD_W-1:0]                             result;
      logic                                                         ready;
      logic [adc_frame_pkg::NUM_CH-1:0][adc_frame_pkg::RANGE_W-1:0] range;
      logic [adc_frame_pkg::ALARM_W-1:0]                            active;
      logic [adc_frame_pkg::ALARM_W-1:0]                            tripped;
   } sys_t;

   typedef struct packed {
      logic [4:0]                       cnt;
      logic [adc_frame_pkg::WORD_W-1:0] sh_in;
      logic [adc_frame_pkg::WORD_W-1:0] sh_out;
      logic                             sdo;
   } frame_t;

   typedef struct packed {
      logic [adc_frame_pkg::WORD_W-1:0] cfg_word;
      logic                             cfg_tgl;
      logic                             rdy_s1;
      logic                             rdy_s2;
      logic                             alm_s1;
      logic                             alm_s2;
      logic                             alarm;
   } link_t;

   localparam sys_t SYS_INIT = '{
      cs_s1: 1'b1, cs_s2: 1'b1, cs_s3: 1'b1, pin_s1: 1'b1, pin_s2: 1'b1,
      state: adc_frame_pkg::ST_IDLE, default: '0};

   sys_t   r;
   sys_t   next_r;
   frame_t f;
   frame_t next_f;
   link_t  l;
   link_t  next_l;
   logic   frame_rst;

   // per channel alarm update; bit 0 high alarm, bit 1 low alarm
   function automatic logic [1:0] alarm_eval(
      input logic [1:0]                         cur,
      input logic [adc_frame_pkg::CODE_W-1:0]   code,
      input logic [adc_frame_pkg::CODE_W-1:0]   hi_t,
      input logic [adc_frame_pkg::HYST_W-1:0]   hi_h,
      input logic [adc_frame_pkg::CODE_W-1:0]   lo_t,
      input logic [adc_frame_pkg::HYST_W-1:0]   lo_h
   );
      logic signed [adc_frame_pkg::CMP_W-1:0] c;
      logic signed [adc_frame_pkg::CMP_W-1:0] hi_up;
      logic signed [adc_frame_pkg::CMP_W-1:0] hi_dn;
      logic signed [adc_frame_pkg::CMP_W-1:0] lo_dn;
      logic signed [adc_frame_pkg::CMP_W-1:0] lo_up;
      logic [1:0]                             res;
      c     = $signed({2'b00, code});
      hi_up = $signed({2'b00, hi_t}) + $signed({6'h00, hi_h});
      hi_dn = $signed({2'b00, hi_t}) - $signed({6'h00, hi_h}) - $signed(adc_frame_pkg::HI_CLR_OFS);
      lo_dn = $signed({2'b00, lo_t}) - $signed({6'h00, lo_h}) - $signed(adc_frame_pkg::LO_OFS);
      lo_up = $signed({2'b00, lo_t}) + $signed({6'h00, lo_h}) + $signed(adc_frame_pkg::LO_OFS);
      res   = cur;
      if (!cur[0] && (c > hi_up))
         res[0] = 1'b1;
      else if (cur[0] && (c <= hi_dn))
         res[0] = 1'b0;
      if (!cur[1] && (c < lo_dn))
         res[1] = 1'b1;
      else if (cur[1] && (c >= lo_up))
         res[1] = 1'b0;
      return res;
   endfunction

   // ---------------- reference clock domain ----------------
   always_comb
   begin
      logic                                   cs_fall;
      logic [adc_frame_pkg::OP_W-1:0]         op;
      logic [adc_frame_pkg::CH_W-1:0]         ch;
      logic [adc_frame_pkg::RANGE_W-1:0]      rng;
      logic [1:0]                             alm;
      logic                                   prog_rst;
      cs_fall  = 1'b0;
      op       = '0;
      ch       = '0;
      rng      = '0;
      alm      = '0;
      prog_rst = 1'b0;
      next_r   = r;
      next_r.conv_start = 1'b0;
      next_r.cs_s1  = I_CS_N;
      next_r.cs_s2  = r.cs_s1;
      next_r.cs_s3  = r.cs_s2;
      next_r.pin_s1 = I_RESET_POWERDOWN_PIN_N;
      next_r.pin_s2 = r.pin_s1;
      next_r.tg_s1  = l.cfg_tgl;
      next_r.tg_s2  = r.tg_s1;
      next_r.tg_s3  = r.tg_s2;
      // select edges are ignored while powered down
      cs_fall = r.cs_s3 && !r.cs_s2 && !r.power_down_state;

      // reset pin: pulse width measured in reference clocks
      if (!r.pin_s2)
      begin
         if (r.low_cnt != adc_frame_pkg::LOW_CNT_W'(adc_frame_pkg::PD_MIN_CYC))
            next_r.low_cnt = r.low_cnt + 1'b1;
         if (r.low_cnt == adc_frame_pkg::LOW_CNT_W'(adc_frame_pkg::PD_MIN_CYC - 1))
         begin
            next_r.power_down_state = 1'b1;
            prog_rst = 1'b1;
         end
      end
      else
      begin
         // anything past the glitch floor resets, no power-down below 400 ns
         if (r.low_cnt >= adc_frame_pkg::LOW_CNT_W'(adc_frame_pkg::RST_MIN_CYC))
            prog_rst = 1'b1;
         next_r.low_cnt          = '0;
         next_r.power_down_state = 1'b0;
      end

      // frame start: apply last frame's word, then clear flags before new sets
      op  = r.pend_word[adc_frame_pkg::OP_POS +: adc_frame_pkg::OP_W];
      ch  = r.pend_word[adc_frame_pkg::CH_POS +: adc_frame_pkg::CH_W];
      rng = r.pend_word[adc_frame_pkg::RANGE_POS +: adc_frame_pkg::RANGE_W];
      if (cs_fall && r.pend_vld)
      begin
         next_r.pend_vld = 1'b0;
         case (op)
            adc_frame_pkg::OP_PROG:
               if (rng < adc_frame_pkg::RANGE_COUNT)
               begin
                  next_r.range[ch]  = rng;
                  next_r.prog_done  = 1'b1;
               end
            adc_frame_pkg::OP_MAN:
               if (r.prog_done)
               begin
                  next_r.armed     = 1'b1;
                  next_r.auto_scan = 1'b0;
                  next_r.sel       = ch;
               end
            adc_frame_pkg::OP_AUTO:
               if (r.prog_done)
               begin
                  next_r.armed     = 1'b1;
                  next_r.auto_scan = 1'b1;
                  next_r.sel       = '0;
               end
            adc_frame_pkg::OP_READ_ALM:
               next_r.tripped = '0;
            default:
               next_r.pend_vld = 1'b0;
         endcase
      end

      case (r.state)
         adc_frame_pkg::ST_CONV:
            if (I_CONV_DONE)
            begin
               next_r.result = {I_CONV_CODE, adc_frame_pkg::PAD_ZERO};
               next_r.ready  = 1'b1;
               next_r.state  = adc_frame_pkg::ST_READY;
               alm = alarm_eval(r.active[2*r.conv_chan +: 2], I_CONV_CODE,
                                I_HI_THRESH[r.conv_chan], I_HI_HYST[r.conv_chan],
                                I_LO_THRESH[r.conv_chan], I_LO_HYST[r.conv_chan]);
               next_r.active[2*r.conv_chan +: 2] = alm;
               // set after any clear above, so a new trip is never lost
               next_r.tripped[2*r.conv_chan +: 2] = next_r.tripped[2*r.conv_chan +: 2] | alm;
            end
         adc_frame_pkg::ST_READY:
            next_r.state = adc_frame_pkg::ST_READY;
         default:
            next_r.state = adc_frame_pkg::ST_IDLE;
      endcase

      if (cs_fall)
      begin
         next_r.ready = 1'b0;
         next_r.state = adc_frame_pkg::ST_IDLE;
         if (next_r.armed)
         begin
            next_r.conv_start = 1'b1;
            next_r.conv_chan  = next_r.sel;
            next_r.state      = adc_frame_pkg::ST_CONV;
            if (next_r.auto_scan)
               next_r.sel = next_r.sel + 1'b1;
         end
      end

      // a word finished in the link domain; it stays put until the next frame
      if (r.tg_s2 != r.tg_s3)
      begin
         next_r.pend_word = l.cfg_word;
         next_r.pend_vld  = 1'b1;
      end

      if (prog_rst)
      begin
         next_r.range     = '0;
         next_r.prog_done = 1'b0;
         next_r.armed     = 1'b0;
         next_r.auto_scan = 1'b0;
         next_r.sel       = '0;
         next_r.pend_vld  = 1'b0;
         next_r.state     = adc_frame_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
   begin
      if (I_SYS_RST)
         r <= SYS_INIT;
      else
         r <= next_r;
   end

   // ---------------- serial clock domain ----------------
   // frame state ends with the select itself; the serial clock may stop
   assign frame_rst = I_SYS_RST | I_CS_N | r.power_down_state;

   always_comb
   begin
      logic [adc_frame_pkg::WORD_W-1:0] load;
      load   = l.rdy_s2 ? r.result : '0;
      next_f = f;
      next_l = l;
      next_l.rdy_s1 = r.ready;
      next_l.rdy_s2 = l.rdy_s1;
      next_l.alm_s1 = |r.tripped;
      next_l.alm_s2 = l.alm_s1;
      if (f.cnt != adc_frame_pkg::EDGE_DONE)
         next_f.cnt = f.cnt + 1'b1;
      if (f.cnt < adc_frame_pkg::EDGE_DONE)
      begin
         next_f.sh_in = {f.sh_in[adc_frame_pkg::WORD_W-2:0], I_SDI};
         next_f.sdo   = 1'b0;
      end
      if (f.cnt == adc_frame_pkg::EDGE_LAST)
      begin
         // data is only valid if conversion beat this edge
         next_f.sdo    = load[adc_frame_pkg::WORD_W-1];
         next_f.sh_out = load;
         next_l.cfg_word = {f.sh_in[adc_frame_pkg::WORD_W-2:0], I_SDI};
         next_l.cfg_tgl  = ~l.cfg_tgl;
         next_l.alarm    = l.alm_s2;
      end
      else if (f.cnt == adc_frame_pkg::EDGE_DONE)
      begin
         next_f.sdo    = f.sh_out[adc_frame_pkg::WORD_W-2];
         next_f.sh_out = {f.sh_out[adc_frame_pkg::WORD_W-2:0], I_DAISY};
      end
   end

   always_ff @(negedge I_SCLK or posedge frame_rst)
   begin
      if (frame_rst)
         f <= '0;
      else
         f <= next_f;
   end

   always_ff @(negedge I_SCLK or posedge I_SYS_RST)
   begin
      if (I_SYS_RST)
         l <= '0;
      else
         l <= next_l;
   end

   // ---------------- outputs ----------------
   assign O_SDO              = f.sdo;
   assign O_SDO_OE           = ~I_CS_N & ~r.power_down_state;
   assign O_ALARM            = l.alarm;
   assign O_CONV_START       = r.conv_start;
   assign O_CONV_CHANNEL     = r.conv_chan;
   assign O_RESULT_READY     = r.ready;
   assign O_RANGE            = r.range;
   assign O_ALARM_ACTIVE     = r.active;
   assign O_ALARM_TRIPPED    = r.tripped;
   assign O_POWER_DOWN_STATE = r.power_down_state;

   // ---------------- assertions ----------------
   a_result_format: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
      (r.state == adc_frame_pkg::ST_CONV && I_CONV_DONE && !r.cs_s3 && r.cs_s2 == r.cs_s3)
      |=> (r.result == {$past(I_CONV_CODE), adc_frame_pkg::PAD_ZERO}) && r.ready)
      else $error("result word not loaded as code plus zero pad");

   a_hi_alarm_set: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
      (r.state == adc_frame_pkg::ST_CONV && I_CONV_DONE
       && ({2'b00, I_CONV_CODE} > ({2'b00, I_HI_THRESH[r.conv_chan]} + {6'h00, I_HI_HYST[r.conv_chan]})))
      |=> r.active[2*$past(r.conv_chan)] && r.tripped[2*$past(r.conv_chan)])
      else $error("high alarm did not set above upper limit");

   a_hi_alarm_hold: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
      (r.state == adc_frame_pkg::ST_CONV && I_CONV_DONE && r.active[2*r.conv_chan]
       && ({2'b00, I_CONV_CODE} + 14'h0002 + {6'h00, I_HI_HYST[r.conv_chan]} > {2'b00, I_HI_THRESH[r.conv_chan]}))
      |=> r.active[2*$past(r.conv_chan)])
      else $error("high alarm cleared above its lower limit");

   a_lo_alarm_set: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
      (r.state == adc_frame_pkg::ST_CONV && I_CONV_DONE
       && ({2'b00, I_CONV_CODE} + {6'h00, I_LO_HYST[r.conv_chan]} + 14'h0001 < {2'b00, I_LO_THRESH[r.conv_chan]}))
      |=> r.active[2*$past(r.conv_chan)+1])
      else $error("low alarm did not set below lower limit");

   a_lo_alarm_clr: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
      (r.state == adc_frame_pkg::ST_CONV && I_CONV_DONE
       && ({2'b00, I_CONV_CODE} >= {2'b00, I_LO_THRESH[r.conv_chan]} + {6'h00, I_LO_HYST[r.conv_chan]} + 14'h0001))
      |=> !r.active[2*$past(r.conv_chan)+1])
      else $error("low alarm did not clear at upper limit");

   a_trip_latched: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
      !(r.cs_s3 && !r.cs_s2 && r.pend_vld && r.pend_word[15:12] == adc_frame_pkg::OP_READ_ALM)
      |=> ((r.tripped & $past(r.tripped)) == $past(r.tripped)))
      else $error("tripped flag dropped without a flag read");

   a_start_on_select: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
      (r.cs_s3 && !r.cs_s2 && !r.power_down_state && r.armed && !r.pend_vld)
      |=> r.conv_start && r.state == adc_frame_pkg::ST_CONV && r.conv_chan == $past(r.sel))
      else $error("select fall did not start conversion on selected channel");

   a_powerdown_entry: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
      (!r.pin_s2 && r.low_cnt == 7'h63) |=> r.power_down_state ##0 !r.prog_done ##0 !r.armed)
      else $error("long reset pulse did not power down");

   a_short_reset: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
      (r.pin_s2 && r.low_cnt >= 7'h0A && r.low_cnt <= 7'h19) |=> !r.power_down_state && !r.prog_done)
      else $error("short reset pulse mishandled");

   a_sdo_low_early: assert property (@(negedge I_SCLK) disable iff (frame_rst)
      (f.cnt < 5'h0E) |=> !f.sdo)
      else $error("serial output not low before 16th edge");

   a_sdo_msb: assert property (@(negedge I_SCLK) disable iff (frame_rst)
      (f.cnt == 5'h0F && l.rdy_s2) |=> f.sdo == r.result[15])
      else $error("result MSB not driven on 16th edge");

   a_alarm_pin_edge: assert property (@(negedge I_SCLK) disable iff (frame_rst)
      (f.cnt != 5'h0F) |=> $stable(l.alarm))
      else $error("alarm pin changed away from 16th edge");

endmodule // adc_frame_alarm_control

// File: bench/host_link_model.sv
// host end of the serial link: sends one word per frame, gathers the reply
module host_link_model (
   input  wire logic        i_go,
   input  wire logic [15:0] i_word,
   input  wire logic        i_sdo,
   output logic             o_sclk,
   output logic             o_cs_n,
   output logic             o_sdi,
   output logic             o_done,
   output logic [31:0]      o_rx
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {o_sclk, o_cs_n, o_sdi, o_done, o_rx} = {4'h4, 32'h0};
   // clock only inside frames; sdi keeps toggling once the word is taken
   always @(posedge i_go)
   begin
      o_done = 1'b0;
      o_cs_n = 1'b0;
      #40;
      // one edge past the data word so the first chain bit is seen
      for (int i = 0; i < 33; i++)
      begin
         o_sdi  = (i < 16) ? i_word[15 - i] : ~o_sdi;
         o_sclk = 1'b1;
         #32 o_rx = {o_rx[30:0], i_sdo};
         o_sclk = 1'b0;
         #32;
      end
      o_cs_n = 1'b1;
      #40 o_done = 1'b1;
   end
endmodule // host_link_model

// File: bench/adc_frame_alarm_control_bench.sv
// self-checking bench for the converter frame and alarm control
module adc_frame_alarm_control_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, pin = 1, go = 0, start, cdone = 0, sclk, cs_n, sdi, sdo, oe, done, alarm, pd, rdy;
   logic [11:0] code = 0, ccode = 0, rc;
   logic [15:0] word = 0, act, trip;
   logic [31:0] rx;
   logic [2:0]  conv_ch, sel, prev;
   logic [7:0][3:0] rng;
   logic [37:0] e, q[$];
   int err_count = 0, total_checks = 0;
   logic [11:0] tc [8] = '{12'h810, 12'h811, 12'h7EF, 12'h7EE, 12'h1EF, 12'h1EE, 12'h210, 12'h211};
   logic [1:0]  ta [8] = '{2'h0, 2'h1, 2'h1, 2'h0, 2'h0, 2'h2, 2'h2, 2'h0};
   always #2 clk = ~clk;
   // converter answers one cycle after start, well before the 16th edge
   always @(posedge clk)
   begin
      cdone <= start;
      ccode <= code;
   end
   // chain input rides on the host data line, which the host inverts once its word is sent
   adc_frame_alarm_control dut (.I_REF_CLK(clk), .I_SYS_RST(rst), .I_SCLK(sclk), .I_CS_N(cs_n), .I_SDI(sdi),
      .I_DAISY(sdi), .I_RESET_POWERDOWN_PIN_N(pin), .I_CONV_DONE(cdone), .I_CONV_CODE(ccode),
      .I_HI_THRESH({8{12'h800}}), .I_HI_HYST({8{8'h10}}), .I_LO_THRESH({8{12'h200}}), .I_LO_HYST({8{8'h10}}),
      .O_SDO(sdo), .O_SDO_OE(oe), .O_ALARM(alarm), .O_CONV_START(start), .O_CONV_CHANNEL(conv_ch),
      .O_RESULT_READY(rdy), .O_RANGE(rng), .O_ALARM_ACTIVE(act), .O_ALARM_TRIPPED(trip), .O_POWER_DOWN_STATE(pd));
   host_link_model host (.i_go(go), .i_word(word), .i_sdo(oe ? sdo : 1'b1), .o_sclk(sclk), .o_cs_n(cs_n),
      .o_sdi(sdi), .o_done(done), .o_rx(rx));
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      total_checks++;
      if (g !== x)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, x, g);
      end
   endtask
   // 15 idle bits, result word, then the chain bit taken on the 17th edge
   function automatic logic [31:0] rx_word(input logic [11:0] c, input logic d);
      return {15'h0, c, 4'h0, d};
   endfunction
   task automatic frame(input logic [15:0] w, input logic [11:0] c, input logic [37:0] x);
      code <= c;
      word <= w;
      go   <= 1'b1;
      q.push_back(x);
      @(posedge clk);
      go <= 1'b0;
      for (int i = 0; i < 800 && done !== 1'b1; i++)
         @(posedge clk);
      if (done !== 1'b1)
         err_count++;
      repeat (4) @(posedge clk);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge done)
   begin
      e = q.pop_front();
      if (!e[37])
      begin
         chk("sdo_word", e[31:0], rx);
         chk("channel", 32'(e[34:32]), 32'(conv_ch));
         chk("alarm_active", 32'(e[36:35]), 32'(act[5:4]));
         chk("result_ready", 32'(|e[16:5]), 32'(rdy));
      end
   end
   initial
   begin
      repeat (30000) @(posedge clk);
      err_count++;
      tally_and_finish;
   end
   initial
   begin
      void'($urandom(32'h2932));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      frame(16'h1205, 12'h0, '0);
      frame(16'hC200, 12'h0, 38'h1);
      chk("range", 32'h5, 32'(rng[2]));
      for (int i = 0; i < 8; i++)
         frame(16'hC200, tc[i], {1'b0, ta[i], 3'h2, rx_word(tc[i], 1'b1)});
      chk("tripped", 32'h3, 32'(trip[5:4]));
      chk("alarm_pin", 32'h1, 32'(alarm));
      prev = 3'h2;
      repeat (6)
      begin
         sel = 3'($urandom);
         rc  = 12'h212 + 12'($urandom % 1500);
         frame({4'hC, 1'b0, sel, 8'h0}, rc, {1'b0, 2'h0, prev, rx_word(rc, 1'b1)});
         prev = sel;
      end
      frame(16'h8000, 12'h400, {1'b0, 2'h0, prev, rx_word(12'h400, 1'b1)});
      frame(16'h0000, 12'h400, {1'b0, 2'h0, prev, rx_word(12'h400, 1'b1)});
      chk("tripped_clear", 32'h0, 32'(trip[5:4]));
      chk("alarm_clear", 32'h0, 32'(alarm));
      pin <= 1'b0;
      repeat (15) @(posedge clk);
      pin <= 1'b1;
      repeat (6) @(posedge clk);
      chk("range_reset", 32'h0, 32'(rng[2]));
      chk("no_powerdown", 32'h0, 32'(pd));
      pin <= 1'b0;
      repeat (110) @(posedge clk);
      chk("powerdown", 32'h1, 32'(pd));
      // released output reads as the pull-up level; this program word must be dropped
      frame(16'h1000, 12'h300, {1'b0, 2'h0, prev, 32'hFFFFFFFF});
      pin <= 1'b1;
      repeat (6) @(posedge clk);
      chk("wake", 32'h0, 32'(pd));
      frame(16'hA000, 12'h300, {1'b0, 2'h0, prev, 32'h1});
      frame(16'h1000, 12'h300, {1'b0, 2'h0, prev, 32'h1});
      frame(16'hA000, 12'h300, {1'b0, 2'h0, prev, 32'h1});
      frame(16'h0000, 12'h300, {1'b0, 2'h0, 3'h0, rx_word(12'h300, 1'b1)});
      frame(16'h0000, 12'h5A5, {1'b0, 2'h0, 3'h1, rx_word(12'h5A5, 1'b1)});
      tally_and_finish;
   end
endmodule // adc_frame_alarm_control_bench
